// file: verilog/irc_config_regs.sv
// Functional notes
// [RL1] input four rank: lower nonzero ranks higher; zero removes it from selection
// [RL2] path select bit steers rank access to main or aux copy, each own default
// [RL3] source byte: bit7 predivide, bit6 lock 8k, bits5:4 profile, bits3:0 code
// [RL4] software sets code to 8 kHz whenever predivide-all is set
// [RL5] lock-at-8k routes input through preset divider; clear means direct to dpll; dpll_direct here also needs predivide clear
// [RL6] frequency code decodes to nominal rate; unused codes flagged invalid
// [RL7] inputs two to four share the layout; three and four reset to code 0011
// [RL8] two-bit profile field picks one of four leaky-bucket configurations
module irc_config_regs
  import irc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [IRC_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic [IRC_DATA_W-1:0] cfg_wr_data,
  input wire logic cfg_rd_en,
  output logic [IRC_DATA_W-1:0] cfg_rd_data,
  output logic cfg_rd_valid,
  input wire logic sonet_sdh_rate_select,
  output logic path_bank_select,
  output logic [IRC_RANK_W-1:0] main_path_rank,
  output logic [IRC_RANK_W-1:0] aux_path_rank,
  output logic main_path_input4_enabled,
  output logic aux_path_input4_enabled,
  output logic [IRC_NUM_INPUTS-1:0] predivide_all,
  output logic [IRC_NUM_INPUTS-1:0] lock_at_8k,
  output logic [IRC_NUM_INPUTS-1:0] dpll_direct,
  output logic [IRC_NUM_INPUTS-1:0] predivide_code_conflict,
  output logic [IRC_NUM_INPUTS*IRC_PROF_W-1:0] activity_profile_choice,
  output logic [IRC_NUM_INPUTS*IRC_NUM_PROFILES-1:0] activity_bucket_onehot,
  output logic [IRC_NUM_INPUTS*IRC_CODE_W-1:0] input_freq_code,
  output logic [IRC_NUM_INPUTS*IRC_KHZ_W-1:0] freq_khz,
  output logic [IRC_NUM_INPUTS-1:0] freq_code_valid
);

  logic [IRC_DATA_W-1:0] src_cfg [IRC_NUM_INPUTS];
  logic [IRC_DATA_W-1:0] next_src_cfg [IRC_NUM_INPUTS];
  logic [IRC_RANK_W-1:0] next_main_rank;
  logic [IRC_RANK_W-1:0] next_aux_rank;
  logic next_path_sel;
  logic [IRC_DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic addr_mapped;

  // write decode for all registers
  always_comb
  begin
    for (int i = 0; i < IRC_NUM_INPUTS; i++)
    begin
      next_src_cfg[i] = src_cfg[i];
      if (cfg_wr_en && cfg_addr == IRC_SRC_ADDR[i])
        next_src_cfg[i] = cfg_wr_data; // RL3 RL7
    end
    next_main_rank = main_path_rank;
    next_aux_rank = aux_path_rank;
    if (cfg_wr_en && cfg_addr == IRC_ADDR_RANK4)
    begin
      if (path_bank_select)
        next_aux_rank = cfg_wr_data[IRC_RANK_LO +: IRC_RANK_W]; // RL2
      else
        next_main_rank = cfg_wr_data[IRC_RANK_LO +: IRC_RANK_W]; // RL2
    end
    next_path_sel = path_bank_select;
    if (cfg_wr_en && cfg_addr == IRC_ADDR_PATH_SEL)
      next_path_sel = cfg_wr_data[IRC_PATH_SEL_BIT];
  end

  // register storage
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IRC_NUM_INPUTS; i++)
        src_cfg[i] <= IRC_SRC_RESET[i]; // RL7
      main_path_rank <= IRC_MAIN_RANK_RESET; // RL2
      aux_path_rank <= IRC_AUX_RANK_RESET; // RL2
      path_bank_select <= IRC_PATH_SEL_RESET;
    end
    else
    begin
      for (int i = 0; i < IRC_NUM_INPUTS; i++)
        src_cfg[i] <= next_src_cfg[i];
      main_path_rank <= next_main_rank;
      aux_path_rank <= next_aux_rank;
      path_bank_select <= next_path_sel;
    end
  end

  // read mux; unmapped addresses read zero, unused bits read zero
  always_comb
  begin
    next_rd_data = '0;
    addr_mapped = 1'b0;
    next_rd_valid = cfg_rd_en;
    for (int i = 0; i < IRC_NUM_INPUTS; i++)
    begin
      if (cfg_addr == IRC_SRC_ADDR[i])
      begin
        next_rd_data = src_cfg[i];
        addr_mapped = 1'b1;
      end
    end
    if (cfg_addr == IRC_ADDR_RANK4)
    begin
      next_rd_data[IRC_RANK_LO +: IRC_RANK_W] =
        path_bank_select ? aux_path_rank : main_path_rank; // RL2
      addr_mapped = 1'b1;
    end
    if (cfg_addr == IRC_ADDR_PATH_SEL)
    begin
      next_rd_data[IRC_PATH_SEL_BIT] = path_bank_select;
      addr_mapped = 1'b1;
    end
    if (!cfg_rd_en)
      next_rd_data = '0;
  end

  // read data register, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_rd_data <= '0;
      cfg_rd_valid <= 1'b0;
    end
    else
    begin
      cfg_rd_data <= next_rd_data;
      cfg_rd_valid <= next_rd_valid;
    end
  end

  // a zero rank takes input four out of automatic selection
  assign main_path_input4_enabled = (main_path_rank != IRC_RANK_OFF); // RL1
  assign aux_path_input4_enabled = (aux_path_rank != IRC_RANK_OFF); // RL1

  // per-input field split, routing and rate decode
  for (genvar g = 0; g < IRC_NUM_INPUTS; g++)
  begin : g_input
    assign predivide_all[g] = src_cfg[g][IRC_PREDIV_BIT]; // RL3
    assign lock_at_8k[g] = src_cfg[g][IRC_LOCK8K_BIT]; // RL3
    assign activity_profile_choice[g*IRC_PROF_W +: IRC_PROF_W] =
      src_cfg[g][IRC_PROF_LO +: IRC_PROF_W]; // RL3
    assign input_freq_code[g*IRC_CODE_W +: IRC_CODE_W] =
      src_cfg[g][IRC_CODE_LO +: IRC_CODE_W]; // RL3
    // neither divider chosen means the input feeds the dpll unchanged
    assign dpll_direct[g] = !src_cfg[g][IRC_LOCK8K_BIT]
      && !src_cfg[g][IRC_PREDIV_BIT]; // RL5
    // software slip: predivide set but code is not 8 kHz
    assign predivide_code_conflict[g] = src_cfg[g][IRC_PREDIV_BIT]
      && (src_cfg[g][IRC_CODE_LO +: IRC_CODE_W] != IRC_FREQ_8K); // RL4
    assign activity_bucket_onehot[g*IRC_NUM_PROFILES +: IRC_NUM_PROFILES] =
      IRC_NUM_PROFILES'(1) << src_cfg[g][IRC_PROF_LO +: IRC_PROF_W]; // RL8

    irc_freq_decode u_decode (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .freq_code(src_cfg[g][IRC_CODE_LO +: IRC_CODE_W]),
      .sonet_sdh_rate_select(sonet_sdh_rate_select),
      .freq_khz(freq_khz[g*IRC_KHZ_W +: IRC_KHZ_W]),
      .freq_code_valid(freq_code_valid[g])
    ); // RL6
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // rank write steps and the held 19.44 MHz code on input four
  sequence s_rank_wr_main;
    cfg_wr_en && cfg_addr == IRC_ADDR_RANK4 && !path_bank_select;
  endsequence

  sequence s_rank_wr_aux;
    cfg_wr_en && cfg_addr == IRC_ADDR_RANK4 && path_bank_select;
  endsequence

  sequence s_code_19m44_held;
    (input_freq_code[3*IRC_CODE_W +: IRC_CODE_W] == IRC_FREQ_19M44) [*2];
  endsequence

  // a zero written to the main copy must drop input four out of selection
  property p_rank_zero_off;
    s_rank_wr_main |=> main_path_input4_enabled == (($past(cfg_wr_data) & 8'h0f) != 8'h00);
  endproperty
  a_rank_zero_off: assert property (p_rank_zero_off) else $error("rank zero not disabling"); // RL1

  property p_rank_main;
    s_rank_wr_main |=> ({4'h0, main_path_rank} == ($past(cfg_wr_data) & 8'h0f))
      && $stable(aux_path_rank);
  endproperty
  a_rank_main: assert property (p_rank_main) else $error("main rank write wrong"); // RL2

  property p_rank_aux;
    s_rank_wr_aux |=> ({4'h0, aux_path_rank} == ($past(cfg_wr_data) & 8'h0f))
      && $stable(main_path_rank);
  endproperty
  a_rank_aux: assert property (p_rank_aux) else $error("aux rank write wrong"); // RL2

  property p_src4_fields;
    cfg_wr_en && cfg_addr == IRC_SRC_ADDR[3] |=>
      {predivide_all[3], lock_at_8k[3], activity_profile_choice[7:6],
       input_freq_code[15:12]} == $past(cfg_wr_data);
  endproperty
  a_src4_fields: assert property (p_src4_fields) else $error("source fields wrong"); // RL3

  property p_route;
    cfg_wr_en && cfg_addr == IRC_SRC_ADDR[3] |=>
      dpll_direct[3] == (($past(cfg_wr_data) & 8'hc0) == 8'h00);
  endproperty
  a_route: assert property (p_route) else $error("dpll routing wrong"); // RL5

  property p_decode_19m44;
    s_code_19m44_held |-> freq_khz[3*IRC_KHZ_W +: IRC_KHZ_W] == IRC_KHZ_19M44
      && freq_code_valid[3];
  endproperty
  a_decode_19m44: assert property (p_decode_19m44) else $error("rate decode wrong"); // RL6

  property p_reset_values;
    @(posedge sys_clk) disable iff (1'b0)
    !rst_n |=> input_freq_code[11:8] == IRC_FREQ_19M44
      && input_freq_code[15:12] == IRC_FREQ_19M44
      && src_cfg[0] == 8'h00 && src_cfg[1] == 8'h00
      && main_path_rank == IRC_MAIN_RANK_RESET && aux_path_rank == IRC_AUX_RANK_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // RL7

  property p_bucket;
    cfg_wr_en && cfg_addr == IRC_SRC_ADDR[3] |=>
      activity_bucket_onehot[15:12] == (4'h1 << (($past(cfg_wr_data) >> 4) & 8'h03));
  endproperty
  a_bucket: assert property (p_bucket) else $error("bucket select wrong"); // RL8

  property p_unmapped_read;
    cfg_rd_en && !addr_mapped |=> cfg_rd_valid && cfg_rd_data == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

endmodule

// file: verilog/irc_pkg.sv
package irc_pkg;

  // geometry of the bank
  localparam int IRC_NUM_INPUTS = 4;
  localparam int IRC_ADDR_W = 8;
  localparam int IRC_DATA_W = 8;
  localparam int IRC_RANK_W = 4;
  localparam int IRC_CODE_W = 4;
  localparam int IRC_PROF_W = 2;
  localparam int IRC_NUM_PROFILES = 4;
  localparam int IRC_KHZ_W = 17;

  // register addresses
  localparam logic [IRC_ADDR_W-1:0] IRC_ADDR_RANK4 = 8'h1c;
  localparam logic [IRC_ADDR_W-1:0] IRC_ADDR_PATH_SEL = 8'h4b;
  localparam logic [IRC_ADDR_W-1:0] IRC_SRC_ADDR [IRC_NUM_INPUTS] =
    '{8'h22, 8'h23, 8'h27, 8'h28};

  // reset values and the rank value that removes input four
  localparam logic [IRC_DATA_W-1:0] IRC_SRC_RESET [IRC_NUM_INPUTS] =
    '{8'h00, 8'h00, 8'h03, 8'h03};
  localparam logic [IRC_RANK_W-1:0] IRC_MAIN_RANK_RESET = 4'h5;
  localparam logic [IRC_RANK_W-1:0] IRC_AUX_RANK_RESET = 4'h0;
  localparam logic IRC_PATH_SEL_RESET = 1'b0;
  localparam logic [IRC_RANK_W-1:0] IRC_RANK_OFF = 4'h0;

  // field positions in the source configuration, rank and path select bytes
  localparam int IRC_PREDIV_BIT = 7;
  localparam int IRC_LOCK8K_BIT = 6;
  localparam int IRC_PROF_LO = 4;
  localparam int IRC_CODE_LO = 0;
  localparam int IRC_PATH_SEL_BIT = 4;
  localparam int IRC_RANK_LO = 0;

  // frequency codes
  typedef enum logic [IRC_CODE_W-1:0] {
    IRC_FREQ_8K     = 4'b0000,
    IRC_FREQ_T1E1   = 4'b0001,
    IRC_FREQ_6M48   = 4'b0010,
    IRC_FREQ_19M44  = 4'b0011,
    IRC_FREQ_25M92  = 4'b0100,
    IRC_FREQ_38M88  = 4'b0101,
    IRC_FREQ_51M84  = 4'b0110,
    IRC_FREQ_77M76  = 4'b0111,
    IRC_FREQ_2K     = 4'b1001,
    IRC_FREQ_4K     = 4'b1010
  } irc_freq_t;

  // nominal rates in kHz
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_NONE = 17'h00000;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_8K = 17'd8;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_1544 = 17'd1544;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_2048 = 17'd2048;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_6M48 = 17'd6480;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_19M44 = 17'd19440;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_25M92 = 17'd25920;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_38M88 = 17'd38880;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_51M84 = 17'd51840;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_77M76 = 17'd77760;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_2K = 17'd2;
  localparam logic [IRC_KHZ_W-1:0] IRC_KHZ_4K = 17'd4;

endpackage

// file: verilog/irc_freq_decode.sv
module irc_freq_decode
  import irc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [IRC_CODE_W-1:0] freq_code,
  input wire logic sonet_sdh_rate_select,
  output logic [IRC_KHZ_W-1:0] freq_khz,
  output logic freq_code_valid
);

  logic [IRC_KHZ_W-1:0] next_freq_khz;
  logic next_freq_code_valid;

  // map the frequency code to a nominal rate, unused codes flagged
  always_comb
  begin
    next_freq_code_valid = 1'b1;
    case (freq_code)
      IRC_FREQ_8K: next_freq_khz = IRC_KHZ_8K; // RL6
      IRC_FREQ_T1E1: next_freq_khz = sonet_sdh_rate_select ? IRC_KHZ_1544 : IRC_KHZ_2048; // RL6
      IRC_FREQ_6M48: next_freq_khz = IRC_KHZ_6M48;
      IRC_FREQ_19M44: next_freq_khz = IRC_KHZ_19M44;
      IRC_FREQ_25M92: next_freq_khz = IRC_KHZ_25M92;
      IRC_FREQ_38M88: next_freq_khz = IRC_KHZ_38M88;
      IRC_FREQ_51M84: next_freq_khz = IRC_KHZ_51M84;
      IRC_FREQ_77M76: next_freq_khz = IRC_KHZ_77M76;
      IRC_FREQ_2K: next_freq_khz = IRC_KHZ_2K;
      IRC_FREQ_4K: next_freq_khz = IRC_KHZ_4K;
      default:
      begin
        next_freq_khz = IRC_KHZ_NONE; // RL6
        next_freq_code_valid = 1'b0;
      end
    endcase
  end

  // registered decode
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      freq_khz <= IRC_KHZ_NONE;
      freq_code_valid <= 1'b0;
    end
    else
    begin
      freq_khz <= next_freq_khz;
      freq_code_valid <= next_freq_code_valid;
    end
  end

endmodule

// file: tb/irc_config_regs_tb_top.sv
module irc_config_regs_tb_top
  import irc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [IRC_ADDR_W-1:0] cfg_addr = 8'h00;
  logic cfg_wr_en = 1'b0;
  logic [IRC_DATA_W-1:0] cfg_wr_data = 8'h00;
  logic cfg_rd_en = 1'b0;
  logic sonet_sdh_rate_select = 1'b0;
  logic [IRC_DATA_W-1:0] cfg_rd_data;
  logic cfg_rd_valid;
  logic path_bank_select;
  logic [IRC_RANK_W-1:0] main_path_rank;
  logic [IRC_RANK_W-1:0] aux_path_rank;
  logic main_path_input4_enabled;
  logic aux_path_input4_enabled;
  logic [IRC_NUM_INPUTS-1:0] predivide_all;
  logic [IRC_NUM_INPUTS-1:0] lock_at_8k;
  logic [IRC_NUM_INPUTS-1:0] dpll_direct;
  logic [IRC_NUM_INPUTS-1:0] predivide_code_conflict;
  logic [IRC_NUM_INPUTS*IRC_PROF_W-1:0] activity_profile_choice;
  logic [IRC_NUM_INPUTS*IRC_NUM_PROFILES-1:0] activity_bucket_onehot;
  logic [IRC_NUM_INPUTS*IRC_CODE_W-1:0] input_freq_code;
  logic [IRC_NUM_INPUTS*IRC_KHZ_W-1:0] freq_khz;
  logic [IRC_NUM_INPUTS-1:0] freq_code_valid;
  int num_errors = 0;
  int check_count = 0;
  int src [4];
  int rank [2];
  int sel;
  int k;
  logic [7:0] d;
  logic [7:0] alist [7] = '{8'h22, 8'h23, 8'h27, 8'h28, 8'h1c, 8'h4b, 8'h30};

  irc_config_regs i_irc_config_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_en(cfg_rd_en), .cfg_rd_data(cfg_rd_data),
    .cfg_rd_valid(cfg_rd_valid), .sonet_sdh_rate_select(sonet_sdh_rate_select),
    .path_bank_select(path_bank_select), .main_path_rank(main_path_rank),
    .aux_path_rank(aux_path_rank), .main_path_input4_enabled(main_path_input4_enabled),
    .aux_path_input4_enabled(aux_path_input4_enabled), .predivide_all(predivide_all),
    .lock_at_8k(lock_at_8k), .dpll_direct(dpll_direct),
    .predivide_code_conflict(predivide_code_conflict),
    .activity_profile_choice(activity_profile_choice),
    .activity_bucket_onehot(activity_bucket_onehot), .input_freq_code(input_freq_code),
    .freq_khz(freq_khz), .freq_code_valid(freq_code_valid)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic results();
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // nominal rate of a frequency code in khz, 0 for unused codes
  function automatic int khz(int c);
    case (c)
      0: return 8;
      1: return sonet_sdh_rate_select ? 1544 : 2048;
      2: return 6480;
      3: return 19440;
      4: return 25920;
      5: return 38880;
      6: return 51840;
      7: return 77760;
      9: return 2;
      10: return 4;
      default: return 0;
    endcase
  endfunction

  // model readback value of an address
  function automatic int expv(logic [7:0] a);
    int r;
    r = 0;
    if (a == IRC_ADDR_RANK4) r = rank[sel];
    if (a == IRC_ADDR_PATH_SEL) r = sel << 4;
    for (int i = 0; i < 4; i++) if (a == IRC_SRC_ADDR[i]) r = src[i];
    return r;
  endfunction

  // hold reset four cycles and load the model defaults
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    src = '{0, 0, 3, 3};
    rank = '{5, 0};
    sel = 0;
  endtask

  // one write cycle, model updated at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_addr <= a;
    cfg_wr_data <= v;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
    if (a == IRC_ADDR_RANK4) rank[sel] = v[3:0];
    if (a == IRC_ADDR_PATH_SEL) sel = v[4];
    for (int i = 0; i < 4; i++) if (a == IRC_SRC_ADDR[i]) src[i] = v;
  endtask

  // one read cycle, answer checked one cycle later
  task automatic rd(input logic [7:0] a);
    int e;
    e = expv(a);
    @(posedge sys_clk);
    cfg_rd_en <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd_en <= 1'b0;
    #1;
    chk({cfg_rd_valid, cfg_rd_data}, {1'b1, e[7:0]});
  endtask

  task automatic check_regs();
    for (int i = 0; i < 7; i++) rd(alist[i]);
  endtask

  // compare all decoded outputs against the model
  task automatic chk_out();
    int c;
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      c = src[i] & 15;
      chk({predivide_all[i], lock_at_8k[i], activity_profile_choice[2*i+:2],
           input_freq_code[4*i+:4]}, src[i][7:0]);
      chk(dpll_direct[i], !(src[i][7] | src[i][6]));
      chk(predivide_code_conflict[i], src[i][7] && c != 0);
      chk(activity_bucket_onehot[4*i+:4], 4'h1 << src[i][5:4]);
      chk({freq_code_valid[i], freq_khz[17*i+:17]}, {khz(c) != 0, 17'(khz(c))});
    end
    chk({path_bank_select, main_path_rank, aux_path_rank},
        {sel[0], rank[0][3:0], rank[1][3:0]});
    chk({main_path_input4_enabled, aux_path_input4_enabled},
        {rank[0] != 0, rank[1] != 0});
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    results();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hc3ae6eb5));
    do_reset();
    chk_out();
    check_regs();
    // each path keeps its own rank, upper bits dropped
    wr(IRC_ADDR_RANK4, 8'hf9);
    wr(IRC_ADDR_PATH_SEL, 8'hff);
    wr(IRC_ADDR_RANK4, 8'h00);
    chk_out();
    check_regs();
    wr(IRC_ADDR_RANK4, 8'h0f);
    wr(IRC_ADDR_PATH_SEL, 8'h00);
    wr(IRC_ADDR_RANK4, 8'h01);
    wr(8'h30, 8'hff);
    chk_out();
    check_regs();
    // every frequency code, code c on input c mod 4, random upper fields
    for (k = 0; k < 32; k++)
    begin
      @(posedge sys_clk);
      sonet_sdh_rate_select <= 1'($urandom);
      d = 8'($urandom);
      d[3:0] = k[3:0];
      if (d[7] && k[4]) d[3:0] = 4'h0;
      wr(IRC_SRC_ADDR[k % 4], d);
      wr(IRC_ADDR_PATH_SEL, 8'($urandom));
      wr(IRC_ADDR_RANK4, 8'($urandom));
      chk_out();
      rd(IRC_SRC_ADDR[k % 4]);
      rd(IRC_ADDR_RANK4);
    end
    // second reset in mid-run restores the defaults
    do_reset();
    chk_out();
    check_regs();
    results();
  end
endmodule
